//--- verilog/epc_toggle_map.vh
// Purpose: constants of the power-condition feature toggle block
// Assumes: word index addressing on the plain register port
// Notes: all offsets are register indexes, not byte addresses
//
// Contract
// - Low nibble of sector number 4h selects enable; upper nibble is reserved.
// - Low nibble of sector number 5h selects disable.
// - Successful enable marks feature set active and sets identify word 120 bit 7.
// - Successful enable turns advanced power management off.
// - On enable, zero saved timer loads current timer from default timer.
// - On enable, nonzero saved timer loads current timer from saved timer.
// - After loading, start each timer that is nonzero and current-enabled.
// - An enabled feature set stays enabled through every kind of reset.
// - Enable is aborted when the feature set is not supported.
// - Successful disable clears identify word 120 bit 7.
// - A disabled feature set stays disabled through every kind of reset.
// - Disable is aborted when unsupported or already disabling.
// - An aborted subcommand leaves every power-condition setting unchanged.
`ifndef EPC_TOGGLE_MAP_VH
`define EPC_TOGGLE_MAP_VH

// Register indexes
`define REG_FEATURE 4'h0
`define REG_SECNUM 4'h1
`define REG_COMMAND 4'h2
`define REG_ERROR 4'h3
`define REG_STATUS 4'h4
`define REG_CONTROL 4'h5
`define REG_STATE 4'h6
`define REG_TINDEX 4'h7
`define REG_TDATA 4'h8
`define REG_CUREN 4'h9
`define REG_RUNNING 4'ha
`define REG_INT_STAT 4'hb
`define REG_INT_CLR 4'hc
`define REG_INT_EN 4'hd

// Command codes
`define CMD_SET_FEATURES 8'hef
`define FEAT_POWER_COND 8'h4a
`define SUB_ENABLE 4'h4
`define SUB_DISABLE 4'h5

// Error and status bit positions
`define ERR_ABORT_BIT 2
`define STAT_BUSY_BIT 7
`define STAT_READY_BIT 6
`define STAT_FAULT_BIT 5
`define STAT_CORR_BIT 2
`define STAT_ERR_BIT 0

// Control and state bit positions
`define CTRL_SUPPORT_BIT 0
`define CTRL_APM_BIT 1
`define STATE_EPC_BIT 0
`define STATE_ID_BIT 1
`define STATE_DISABLING_BIT 2

// Interrupt bits
`define INT_DONE_BIT 0
`define INT_ABORT_BIT 1

// Timer table kinds
`define KIND_SAVED 2'h0
`define KIND_DEFAULT 2'h1
`define KIND_CURRENT 2'h2

// Reset values
`define RST_CONTROL 2'h1
`define RST_STATUS 8'h40

`endif

//--- verilog/epc_timer_ram.v
// Purpose: timer table storage, saved, default and current values
// Assumes: one port, write and read in the same cycle allowed
// Notes: read data come out of a register one cycle after the address
module epc_timer_ram #(
	parameter AW = 4,
	parameter DW = 24
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire we_in,
	input wire [AW-1:0] addr_in,
	input wire [DW-1:0] wdata_in,
	output reg [DW-1:0] rdata_out
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// Array has no reset, only the output register does
	always @(posedge clk_in) begin
		if (we_in) begin
			mem[addr_in] <= wdata_in;
		end
	end

	// Registered read, old data on a write to the same word
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= {DW{1'b0}};
		end else begin
			rdata_out <= mem[addr_in];
		end
	end
endmodule

//--- verilog/epc_toggle.v
// Purpose: enable and disable subcommands of the power-condition feature set
// Assumes: inputs synchronous to CLK_IN; NV_EPC_IN holds the stored setting
// Notes: EPC_EN_OUT must be kept in nonvolatile storage by the system
`include "epc_toggle_map.vh"
module epc_toggle #(
	parameter NCOND = 4,
	parameter IDXW = 2,
	parameter TW = 24
) (
	input wire CLK_IN,
	input wire RST_N_IN,
	input wire DRV_RESET_IN,
	input wire NV_EPC_IN,
	input wire [3:0] ADDR_IN,
	input wire [31:0] WDATA_IN,
	input wire WR_IN,
	input wire RD_IN,
	output wire [31:0] RDATA_OUT,
	output wire EPC_EN_OUT,
	output wire ID120_B7_OUT,
	output wire APM_EN_OUT,
	output wire [NCOND-1:0] TIMER_RUN_OUT,
	output wire BUSY_OUT,
	output wire IRQ_OUT
);
	localparam AW = IDXW + 2;
	// Last index cut from a full-width count so no bits drop silently
	localparam [31:0] LAST_FULL = NCOND - 1;
	localparam [IDXW-1:0] LAST = LAST_FULL[IDXW-1:0];
	localparam [1:0] CTRL_RST = `RST_CONTROL;

	// Sequencer states
	localparam S_IDLE = 3'd0;
	localparam S_EN_SAVED = 3'd1;
	localparam S_EN_DEF = 3'd2;
	localparam S_EN_LOAD = 3'd3;
	localparam S_EN_DONE = 3'd4;
	localparam S_DIS_STOP = 3'd5;
	localparam S_DIS_DONE = 3'd6;

	// Timer table address from kind and condition index
	function [AW-1:0] tab_addr;
		input [1:0] kind;
		input [IDXW-1:0] cond;
		begin
			tab_addr = {kind, cond};
		end
	endfunction

	// Completion status: fault and corrected never set, ready clear only while busy
	function [7:0] status_word;
		input busy_flag;
		input err;
		begin
			status_word = 8'h00;
			status_word[`STAT_BUSY_BIT] = busy_flag;
			status_word[`STAT_READY_BIT] = !busy_flag;
			status_word[`STAT_ERR_BIT] = err;
		end
	endfunction

	// Error register carries only the abort flag
	function [7:0] error_word;
		input command_abort_flag;
		begin
			error_word = 8'h00;
			error_word[`ERR_ABORT_BIT] = command_abort_flag;
		end
	endfunction

	reg [2:0] state;
	reg [2:0] next_state;
	reg [IDXW-1:0] idx;
	reg [TW-1:0] saved_q;
	reg [7:0] feature;
	reg [7:0] secnum;
	reg [7:0] err_reg;
	reg [7:0] stat_reg;
	reg supported;
	reg apm_en;
	reg epc_en;
	reg id_bit;
	reg nv_loaded;
	reg [NCOND-1:0] cur_en;
	reg [NCOND-1:0] run;
	reg [AW-1:0] tindex;
	reg [1:0] int_stat;
	reg [1:0] int_en;
	reg [31:0] rdata_q;
	reg tdat_q;

	wire [TW-1:0] ram_dout;
	reg ram_we;
	reg [AW-1:0] ram_addr;
	reg [TW-1:0] ram_wdata;

	wire busy = (state != S_IDLE);
	wire disabling = (state == S_DIS_STOP) || (state == S_DIS_DONE);
	wire wr_cmd = WR_IN && (ADDR_IN == `REG_COMMAND);
	wire is_pc = (WDATA_IN[7:0] == `CMD_SET_FEATURES) && (feature == `FEAT_POWER_COND);
	wire [3:0] subcode = secnum[3:0];
	// Only the low nibble picks the subcommand, upper nibble ignored
	wire sub_en = (subcode == `SUB_ENABLE);
	wire sub_dis = (subcode == `SUB_DISABLE);
	wire new_cmd = wr_cmd && is_pc && !busy;
	// Abort cases: unsupported, unknown subcommand, or disable while disabling
	wire cmd_abort = (new_cmd && (!supported || !(sub_en || sub_dis)))
		|| (wr_cmd && is_pc && disabling && sub_dis);
	wire start_en = new_cmd && supported && sub_en;
	wire start_dis = new_cmd && supported && sub_dis;
	// A drive reset in the last cycle abandons the sweep, so nothing completes
	wire en_finish = (state == S_EN_DONE) && !DRV_RESET_IN;
	wire dis_finish = (state == S_DIS_DONE) && !DRV_RESET_IN;
	wire done_ev = en_finish || dis_finish;
	// Current value choice between saved and default
	wire [TW-1:0] load_val = (saved_q == {TW{1'b0}}) ? ram_dout : saved_q;

	epc_timer_ram #(
		.AW(AW),
		.DW(TW)
	) u_ram (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.we_in(ram_we),
		.addr_in(ram_addr),
		.wdata_in(ram_wdata),
		.rdata_out(ram_dout)
	);

	// Table port: sequencer owns it while busy, software otherwise
	always @* begin
		ram_we = 1'b0;
		ram_addr = tindex;
		ram_wdata = WDATA_IN[TW-1:0];
		case (state)
			S_IDLE: begin
				ram_we = WR_IN && (ADDR_IN == `REG_TDATA);
			end
			S_EN_SAVED: begin
				ram_addr = tab_addr(`KIND_SAVED, idx);
			end
			S_EN_DEF: begin
				ram_addr = tab_addr(`KIND_DEFAULT, idx);
			end
			S_EN_LOAD: begin
				ram_we = 1'b1;
				ram_addr = tab_addr(`KIND_CURRENT, idx);
				ram_wdata = load_val;
			end
			default: begin
				ram_we = 1'b0;
			end
		endcase
	end

	// Next state of the sequencer; three cycles per condition on enable
	always @* begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (start_en) begin
					next_state = S_EN_SAVED;
				end else if (start_dis) begin
					next_state = S_DIS_STOP;
				end
			end
			S_EN_SAVED: begin
				next_state = S_EN_DEF;
			end
			S_EN_DEF: begin
				next_state = S_EN_LOAD;
			end
			S_EN_LOAD: begin
				next_state = (idx == LAST) ? S_EN_DONE : S_EN_SAVED;
			end
			S_DIS_STOP: begin
				next_state = (idx == LAST) ? S_DIS_DONE : S_DIS_STOP;
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	// Sequencer and condition index; a drive reset abandons the sweep
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state <= S_IDLE;
			idx <= {IDXW{1'b0}};
			saved_q <= {TW{1'b0}};
		end else if (DRV_RESET_IN) begin
			state <= S_IDLE;
			idx <= {IDXW{1'b0}};
		end else begin
			state <= next_state;
			if (state == S_EN_DEF) begin
				saved_q <= ram_dout;
			end
			if (state == S_EN_LOAD || state == S_DIS_STOP) begin
				idx <= (idx == LAST) ? {IDXW{1'b0}} : idx + 1'b1;
			end
		end
	end

	// Timer run flags, started on load, stopped one by one on disable
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			run <= {NCOND{1'b0}};
		end else if (DRV_RESET_IN) begin
			run <= {NCOND{1'b0}};
		end else if (state == S_EN_LOAD) begin
			run[idx] <= (load_val != {TW{1'b0}}) && cur_en[idx];
		end else if (state == S_DIS_STOP) begin
			run[idx] <= 1'b0;
		end
	end

	// Feature state; the async reset gives a constant, the stored value
	// is taken on the first edge after release
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			epc_en <= 1'b0;
			id_bit <= 1'b0;
			nv_loaded <= 1'b0;
		end else if (!nv_loaded) begin
			nv_loaded <= 1'b1;
			epc_en <= NV_EPC_IN;
			id_bit <= NV_EPC_IN;
		end else if (en_finish) begin
			epc_en <= 1'b1;
			id_bit <= 1'b1;
		end else if (dis_finish) begin
			epc_en <= 1'b0;
			id_bit <= 1'b0;
		end
	end

	// Software control bits; drive resets leave them alone
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			supported <= CTRL_RST[`CTRL_SUPPORT_BIT];
			apm_en <= CTRL_RST[`CTRL_APM_BIT];
			cur_en <= {NCOND{1'b0}};
			tindex <= {AW{1'b0}};
			feature <= 8'h00;
			secnum <= 8'h00;
			int_en <= 2'h0;
		end else begin
			if (WR_IN && ADDR_IN == `REG_CONTROL) begin
				supported <= WDATA_IN[`CTRL_SUPPORT_BIT];
				apm_en <= WDATA_IN[`CTRL_APM_BIT];
			end
			if (en_finish) begin
				apm_en <= 1'b0;
			end
			// Current-enable, feature and sector number frozen while the sweep runs, so an abort changes nothing
			if (WR_IN && ADDR_IN == `REG_CUREN && !busy) begin
				cur_en <= WDATA_IN[NCOND-1:0];
			end
			if (WR_IN && ADDR_IN == `REG_TINDEX) begin
				tindex <= WDATA_IN[AW-1:0];
			end
			if (WR_IN && ADDR_IN == `REG_FEATURE && !busy) begin
				feature <= WDATA_IN[7:0];
			end
			if (WR_IN && ADDR_IN == `REG_SECNUM && !busy) begin
				secnum <= WDATA_IN[7:0];
			end
			if (WR_IN && ADDR_IN == `REG_INT_EN) begin
				int_en <= WDATA_IN[1:0];
			end
		end
	end

	// Error and status registers as the host sees them on completion
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			err_reg <= 8'h00;
			stat_reg <= `RST_STATUS;
		end else if (DRV_RESET_IN) begin
			err_reg <= 8'h00;
			stat_reg <= `RST_STATUS;
		// Abort outranks start; a stop sweep hit by a second disable still ends in success
		end else if (cmd_abort) begin
			err_reg <= error_word(1'b1);
			stat_reg <= status_word(1'b0, 1'b1);
		end else if (start_en || start_dis) begin
			err_reg <= error_word(1'b0);
			stat_reg <= status_word(1'b1, 1'b0);
		end else if (done_ev) begin
			err_reg <= error_word(1'b0);
			stat_reg <= status_word(1'b0, 1'b0);
		end
	end

	// Sticky events; a new event beats a clear in the same cycle
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			int_stat <= 2'h0;
		end else begin
			if (WR_IN && ADDR_IN == `REG_INT_CLR) begin
				int_stat <= (int_stat & ~WDATA_IN[1:0]) | {cmd_abort, done_ev};
			end else begin
				int_stat <= int_stat | {cmd_abort, done_ev};
			end
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rdata_q <= 32'h00000000;
			tdat_q <= 1'b0;
		end else begin
			rdata_q <= 32'h00000000;
			tdat_q <= RD_IN && (ADDR_IN == `REG_TDATA) && !busy;
			if (RD_IN) begin
				case (ADDR_IN)
					`REG_FEATURE: rdata_q[7:0] <= feature;
					`REG_SECNUM: rdata_q[7:0] <= secnum;
					`REG_ERROR: rdata_q[7:0] <= err_reg;
					`REG_STATUS: rdata_q[7:0] <= stat_reg;
					`REG_CONTROL: rdata_q[1:0] <= {apm_en, supported};
					`REG_STATE: rdata_q[2:0] <= {disabling, id_bit, epc_en};
					`REG_TINDEX: rdata_q[AW-1:0] <= tindex;
					`REG_CUREN: rdata_q[NCOND-1:0] <= cur_en;
					`REG_RUNNING: rdata_q[NCOND-1:0] <= run;
					`REG_INT_STAT: rdata_q[1:0] <= int_stat;
					`REG_INT_EN: rdata_q[1:0] <= int_en;
					default: rdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	// Table reads come straight from the table's output register
	assign RDATA_OUT = tdat_q ? {{(32-TW){1'b0}}, ram_dout} : rdata_q;
	assign EPC_EN_OUT = epc_en;
	assign ID120_B7_OUT = id_bit;
	assign APM_EN_OUT = apm_en;
	assign TIMER_RUN_OUT = run;
	assign BUSY_OUT = busy;
	assign IRQ_OUT = |(int_stat & int_en);
endmodule

//--- bench/epc_toggle_sva.sv
// Purpose: port checker for the feature toggle block
// Assumes: FEATURE and SECNUM are written before COMMAND
// Notes: shadow copies track feature, subcode and support bit
module epc_toggle_sva #(parameter NCOND = 4) (
	input wire CLK_IN,
	input wire RST_N_IN,
	input wire DRV_RESET_IN,
	input wire NV_EPC_IN,
	input wire [3:0] ADDR_IN,
	input wire [31:0] WDATA_IN,
	input wire WR_IN,
	input wire RD_IN,
	input wire [31:0] RDATA_OUT,
	input wire EPC_EN_OUT,
	input wire ID120_B7_OUT,
	input wire APM_EN_OUT,
	input wire [NCOND-1:0] TIMER_RUN_OUT,
	input wire BUSY_OUT,
	input wire IRQ_OUT
);
	reg [7:0] feat;
	reg [3:0] sub;
	reg sup;
	wire go;
	// Command accepted only when idle
	assign go = WR_IN && ADDR_IN == 4'h2 && WDATA_IN[7:0] == 8'hef && feat == 8'h4a && !BUSY_OUT;
	// Feature and sector number writes while busy are dropped by the block, so they are here too
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			feat <= 8'h0;
			sub <= 4'h0;
			sup <= 1'b1;
		end else begin
			if (WR_IN && !BUSY_OUT && ADDR_IN == 4'h0) feat <= WDATA_IN[7:0];
			if (WR_IN && !BUSY_OUT && ADDR_IN == 4'h1) sub <= WDATA_IN[3:0];
			// Control writes land even while busy
			if (WR_IN && ADDR_IN == 4'h5) sup <= WDATA_IN[0];
		end
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	a_id_mirror: assert property (ID120_B7_OUT == EPC_EN_OUT)
		else $error("identify bit differs");
	a_enable_done: assert property (go && sub == 4'h4 && sup && !EPC_EN_OUT |=>
		BUSY_OUT ##[9:14] (EPC_EN_OUT && !APM_EN_OUT)) else $error("enable late");
	a_disable_done: assert property (go && sub == 4'h5 && sup && EPC_EN_OUT |=>
		BUSY_OUT ##[3:7] (!EPC_EN_OUT && TIMER_RUN_OUT == '0)) else $error("disable late");
	a_abort_keeps: assert property (go && (!sup || (sub != 4'h4 && sub != 4'h5)) |=>
		(!BUSY_OUT && $stable(EPC_EN_OUT))[*3]) else $error("abort changed state");
	a_fall_stopped: assert property ($fell(EPC_EN_OUT) |-> TIMER_RUN_OUT == '0)
		else $error("timer runs after disable");
	a_drv_keeps: assert property (DRV_RESET_IN |=> $stable(EPC_EN_OUT) && !BUSY_OUT)
		else $error("drive reset changed state");
	a_run_busy: assert property ($changed(TIMER_RUN_OUT) |-> $past(BUSY_OUT) || $past(DRV_RESET_IN))
		else $error("run flag moved while idle");
	a_idle_data: assert property (!RD_IN |=> RDATA_OUT == 32'h0)
		else $error("read data outside its cycle");
	a_status_clean: assert property (RD_IN && ADDR_IN == 4'h4 |=> !RDATA_OUT[5] && !RDATA_OUT[2])
		else $error("fault or corrected set");
	c_enable: cover property (go && sub == 4'h4);
	c_disable: cover property (go && sub == 4'h5);
	c_fall: cover property ($fell(EPC_EN_OUT));
endmodule
bind epc_toggle epc_toggle_sva #(.NCOND(NCOND)) chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
	.DRV_RESET_IN(DRV_RESET_IN), .NV_EPC_IN(NV_EPC_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
	.WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .EPC_EN_OUT(EPC_EN_OUT),
	.ID120_B7_OUT(ID120_B7_OUT), .APM_EN_OUT(APM_EN_OUT), .TIMER_RUN_OUT(TIMER_RUN_OUT),
	.BUSY_OUT(BUSY_OUT), .IRQ_OUT(IRQ_OUT));

//--- bench/epc_host_model.sv
// Purpose: host side issuing register cycles and subcommands
// Assumes: one request at a time, strobes one cycle long
// Notes: released address and data show inverted values
module epc_host_model (
	input wire logic clk_in,
	input wire logic [31:0] rdata_in,
	output logic [3:0] addr_out = 4'h0,
	output logic [31:0] wdata_out = 32'h0,
	output logic wr_out = 1'b0,
	output logic rd_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// Single write cycle
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		// Sampled mid-cycle, away from the edge that ends the data
		@(negedge clk_in);
		d = rdata_in;
	endtask
	// Subcommand with reserved upper nibble zero; dup repeats it while busy
	task automatic cmd(input logic [3:0] sub, input logic dup);
		logic [31:0] s;
		int n;
		wr(4'h0, 32'h4a);
		wr(4'h1, {28'h0, sub});
		wr(4'h2, 32'hef);
		if (dup) wr(4'h2, 32'hef);
		s = 32'h80;
		for (n = 0; n < 40 && s[7]; n++) rd(4'h4, s);
	endtask
endmodule

//--- bench/tb.sv
// Purpose: self-checking bench for the feature toggle block
// Assumes: four conditions, nonvolatile setting modelled by a pin
// Notes: expected values come from the register layout
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic drv_rst = 1'b0;
	logic nv_epc = 1'b0;
	logic [3:0] addr;
	logic [31:0] wdata, rdata;
	logic wr, rd, epc_en, id_bit, apm_en, busy, irq;
	logic [3:0] run;
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	always #20 clk = ~clk;
	epc_toggle #(.NCOND(4), .IDXW(2), .TW(24)) dut (.CLK_IN(clk), .RST_N_IN(rst_n), .DRV_RESET_IN(drv_rst),
		.NV_EPC_IN(nv_epc), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.EPC_EN_OUT(epc_en), .ID120_B7_OUT(id_bit), .APM_EN_OUT(apm_en), .TIMER_RUN_OUT(run),
		.BUSY_OUT(busy), .IRQ_OUT(irq));
	epc_host_model host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
		.wr_out(wr), .rd_out(rd));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Ceiling well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] d;
		host.rd(a, d);
		check(d, exp);
	endtask
	task automatic power_up(input logic nv);
		@(posedge clk);
		rst_n <= 1'b0;
		nv_epc <= nv;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		@(negedge clk);
	endtask
	task automatic drive_reset();
		@(posedge clk);
		drv_rst <= 1'b1;
		@(posedge clk);
		drv_rst <= 1'b0;
		@(negedge clk);
	endtask
	task automatic tset(input logic [1:0] k, input logic [1:0] i, input logic [23:0] v);
		host.wr(4'h7, {28'h0, k, i});
		host.wr(4'h8, {8'h0, v});
	endtask
	task automatic t_regs();
		rchk(4'h5, 32'h1);
		rchk(4'h4, 32'h40);
		rchk(4'h3, 32'h0);
		rchk(4'hf, 32'h0);
		check({28'h0, epc_en, id_bit, apm_en, irq}, 32'h0);
		$display("register test done");
	endtask
	// Zero saved entries fall back to defaults; idx2 disabled, idx3 zero
	task automatic t_enable();
		logic [23:0] sv [4] = '{24'h0, 24'h7, 24'h3, 24'h0};
		logic [23:0] dv [4] = '{24'h5, 24'h9, 24'h1, 24'h0};
		for (int i = 0; i < 4; i++) begin
			tset(2'h0, i[1:0], sv[i]);
			tset(2'h1, i[1:0], dv[i]);
		end
		host.wr(4'h9, 32'hb);
		host.wr(4'h5, 32'h3);
		host.wr(4'hd, 32'h3);
		host.cmd(4'h4, 1'b0);
		check({28'h0, epc_en, id_bit, apm_en, 1'b0}, 32'hc);
		check({28'h0, run}, 32'h3);
		rchk(4'h5, 32'h1);
		rchk(4'h4, 32'h40);
		for (int i = 0; i < 4; i++) begin
			host.wr(4'h7, {28'h0, 2'h2, i[1:0]});
			rchk(4'h8, {8'h0, sv[i] != 24'h0 ? sv[i] : dv[i]});
		end
		check({31'h0, irq}, 32'h1);
		host.wr(4'hc, 32'h1);
		rchk(4'hb, 32'h0);
		check({31'h0, irq}, 32'h0);
		$display("enable test done");
	endtask
	task automatic t_abort();
		host.wr(4'h5, 32'h0);
		for (int s = 4; s < 7; s++) begin
			host.cmd(s[3:0], 1'b0);
			rchk(4'h3, 32'h4);
			rchk(4'h4, 32'h41);
			check({28'h0, epc_en, id_bit, apm_en, 1'b0}, 32'hc);
		end
		check({31'h0, irq}, 32'h1);
		host.wr(4'h5, 32'h1);
		host.cmd(4'h6, 1'b0);
		rchk(4'h3, 32'h4);
		check({28'h0, epc_en, id_bit, apm_en, 1'b0}, 32'hc);
		host.wr(4'hc, 32'h3);
		$display("abort test done");
	endtask
	task automatic t_persist();
		drive_reset();
		check({28'h0, epc_en, id_bit, run == 4'h0, busy}, 32'he);
		power_up(1'b1);
		check({30'h0, epc_en, id_bit}, 32'h3);
		$display("persist test done");
	endtask
	// Second command lands while the stop sweep runs
	task automatic t_disable();
		logic [31:0] d;
		host.cmd(4'h5, 1'b1);
		host.rd(4'hb, d);
		check({31'h0, d[1]}, 32'h1);
		check({28'h0, epc_en, id_bit, run == 4'h0, busy}, 32'h2);
		drive_reset();
		check({31'h0, epc_en}, 32'h0);
		power_up(1'b0);
		check({30'h0, epc_en, id_bit}, 32'h0);
		$display("disable test done");
	endtask
	initial begin
		power_up(1'b0);
		t_regs();
		t_enable();
		t_abort();
		t_persist();
		t_disable();
		finish_test();
	end
endmodule
